/* hdl/rmi_pkg.sv */
// shared constants, types and states for the read-only monitor two-wire target
package rmi_pkg;

	// ==========================================
	// register pointers
	localparam logic [7:0] PTR_STATUS = 8'h79;
	localparam logic [7:0] PTR_VIN = 8'h88;
	localparam logic [7:0] PTR_OUTPUT_VOLTAGE_READING = 8'h8B;
	localparam logic [7:0] PTR_OUTPUT_CURRENT_READING = 8'h8C;
	localparam logic [7:0] PTR_TEMP = 8'h8D;

	// ==========================================
	// address bytes, write direction; the read byte differs in bit 0 only
	localparam logic [7:0] ADDR_BYTE_FLOAT = 8'h02;
	localparam logic [7:0] ADDR_BYTE_GND = 8'h06;
	localparam int ADDR_RW_BIT = 0;

	// ==========================================
	// status word layout and reset values
	localparam int FAULT_W = 5;
	localparam int STATUS_NOW_LSB = 0;
	localparam int STATUS_LOG_LSB = 8;
	localparam logic [FAULT_W-1:0] FAULT_RST = 5'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [15:0] UNMAPPED_WORD = 16'h0000;
	localparam logic [7:0] PTR_RST = 8'h00;

	// ==========================================
	// link timing and framing
	localparam int BUS_RATE_KHZ = 100;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;
	localparam logic [3:0] BIT_CNT_RST = 4'h0;

	// ==========================================
	// types
	typedef struct packed {
		logic overtemp_fault;      // bit 4
		logic overcurrent_fault;   // bit 3
		logic regulation_fault;    // bit 2
		logic input_high_fault;    // bit 1
		logic input_low_fault;     // bit 0
	} rmi_fault_t;

	typedef struct packed {
		logic [15:0] input_voltage_reading;    // 1 mV per count
		logic [15:0] output_voltage_reading;   // 1 mV per count
		logic [15:0] output_current_reading;   // 1 mA per count
		logic [15:0] temperature_reading;      // 1 degree per count
	} rmi_tele_t;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_PTR,
		ST_PTR_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RDATA_ACK
	} rmi_state_t;

endpackage : rmi_pkg

/* hdl/rmi_target.sv */
// read-only two-wire monitor target: link engine, word fetch crossing, fault log and remote enable
// What this block does
// RULE1: acts only as a bus target at the 100 kHz standard rate, never drives the clock.
// RULE2: registers are read-only; no write ever changes telemetry or status.
// RULE3: master writes pointer, repeated start, reads two bytes, nacks the second, stops.
// RULE4: acknowledge both address bytes and pointer; return low byte then high byte.
// RULE5: address byte is the strap-chosen physical address plus the direction bit.
// RULE6: strap floating: answer 0x2 for writes and 0x3 for reads.
// RULE7: strap grounded: answer 0x6 for writes and 0x7 for reads.
// RULE8: remote enable is active low; on while held low, off while released.
// RULE9: read-only words: status 0x79, vin 0x88, output_voltage_reading 0x8B, output_current_reading 0x8C, temp 0x8D.
// RULE10: status bits 0-4 show present faults; bits 5-7 read zero.
// RULE11: bits 8-12 log faults; cleared only by reset or enable going off.
// RULE12: data bytes after the pointer are acknowledged and thrown away.
`timescale 1ns/10ps
module rmi_target (
	input wire logic clk_sys,                  // system clock, 250 MHz
	input wire logic nrst,                     // synchronous reset, active low
	input wire logic clk_link,                 // free-running link sampling clock
	input wire logic scl_i,                    // serial clock pin level
	input wire logic sda_i,                    // serial data pin level
	output logic sda_o,                        // serial data drive value
	output logic sda_oe,                       // serial data drive enable, high drives low
	input wire logic addr_strap_i,             // address strap pin, high when floating
	input wire logic remote_en_n_i,            // remote enable pin, active low
	output logic module_on,                    // converter enabled
	input wire rmi_pkg::rmi_fault_t fault_i,   // present shutdown causes
	input wire rmi_pkg::rmi_tele_t tele_i,     // telemetry readings
	output rmi_pkg::rmi_fault_t fault_log      // logged faults
);

	// ==========================================
	// system domain: remote enable and fault log
	logic [2:0] en_sync_reg;
	logic module_on_reg;
	logic module_on_next;
	rmi_pkg::rmi_fault_t log_reg;
	rmi_pkg::rmi_fault_t log_next;

	always_ff @(posedge clk_sys) begin
		en_sync_reg <= {en_sync_reg[1:0], remote_en_n_i};
	end

	// a change counts once the last two stages agree
	always_comb begin
		module_on_next = module_on_reg;
		if (en_sync_reg[2] == en_sync_reg[1]) begin
			module_on_next = ~en_sync_reg[2]; // RULE8
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			module_on_reg <= 1'b0;
		end else begin
			module_on_reg <= module_on_next;
		end
	end

	// set wins over the clear when a fault shows in the off cycle
	always_comb begin
		log_next = log_reg;
		if (module_on_reg && !module_on_next) begin
			log_next = rmi_pkg::FAULT_RST; // RULE11
		end
		log_next = log_next | fault_i; // RULE11
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			log_reg <= rmi_pkg::FAULT_RST;
		end else begin
			log_reg <= log_next;
		end
	end

	assign module_on = module_on_reg;
	assign fault_log = log_reg;

	// ==========================================
	// system domain: word fetch on request toggle from the link
	logic [2:0] req_sync_reg;
	logic req_tgl_reg;
	logic ack_tgl_reg;
	logic [15:0] fetch_word_reg;
	logic [15:0] fetch_word_next;
	logic [7:0] ptr_reg;
	logic [15:0] status_word;

	// reserved bits of both bytes stay zero
	always_comb begin
		status_word = '0;
		status_word[rmi_pkg::STATUS_NOW_LSB +: rmi_pkg::FAULT_W] = fault_i; // RULE10
		status_word[rmi_pkg::STATUS_LOG_LSB +: rmi_pkg::FAULT_W] = log_reg; // RULE11
	end

	always_comb begin
		unique case (ptr_reg)
			rmi_pkg::PTR_STATUS: fetch_word_next = status_word; // RULE9
			rmi_pkg::PTR_VIN: fetch_word_next = tele_i.input_voltage_reading; // RULE9
			rmi_pkg::PTR_OUTPUT_VOLTAGE_READING: fetch_word_next = tele_i.output_voltage_reading; // RULE9
			rmi_pkg::PTR_OUTPUT_CURRENT_READING: fetch_word_next = tele_i.output_current_reading; // RULE9
			rmi_pkg::PTR_TEMP: fetch_word_next = tele_i.temperature_reading; // RULE9
			default: fetch_word_next = rmi_pkg::UNMAPPED_WORD;
		endcase
	end

	// pointer is held steady by the link while a request is open
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			req_sync_reg <= '0;
			ack_tgl_reg <= 1'b0;
			fetch_word_reg <= rmi_pkg::WORD_RST;
		end else begin
			req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
			if (req_sync_reg[2] != req_sync_reg[1]) begin
				fetch_word_reg <= fetch_word_next;
				ack_tgl_reg <= ~ack_tgl_reg;
			end
		end
	end

	// ==========================================
	// link domain: reset and pin sampling
	logic [1:0] lrst_sync_reg;
	logic lrst_n;
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic [2:0] strap_sync_reg;
	logic scl_reg;
	logic sda_reg;
	logic strap_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	always_ff @(posedge clk_link) begin
		lrst_sync_reg <= {lrst_sync_reg[0], nrst};
		scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
		sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
		strap_sync_reg <= {strap_sync_reg[1:0], addr_strap_i};
	end

	assign lrst_n = lrst_sync_reg[1];

	always_ff @(posedge clk_link) begin
		if (!lrst_n) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			strap_reg <= 1'b1;
		end else begin
			if (scl_sync_reg[2] == scl_sync_reg[1]) scl_reg <= scl_sync_reg[2];
			if (sda_sync_reg[2] == sda_sync_reg[1]) sda_reg <= sda_sync_reg[2];
			if (strap_sync_reg[2] == strap_sync_reg[1]) strap_reg <= strap_sync_reg[2];
		end
	end

	assign scl_rise = (scl_sync_reg[2] == scl_sync_reg[1]) && scl_sync_reg[2] && !scl_reg;
	assign scl_fall = (scl_sync_reg[2] == scl_sync_reg[1]) && !scl_sync_reg[2] && scl_reg;
	assign start_det = scl_reg && sda_reg && (sda_sync_reg[2] == sda_sync_reg[1]) && !sda_sync_reg[2]
		&& (scl_sync_reg[2] == scl_sync_reg[1]) && scl_sync_reg[2];
	assign stop_det = scl_reg && !sda_reg && (sda_sync_reg[2] == sda_sync_reg[1]) && sda_sync_reg[2]
		&& (scl_sync_reg[2] == scl_sync_reg[1]) && scl_sync_reg[2];

	// ==========================================
	// link domain: word crossing back from the system side
	logic [2:0] ack_sync_reg;
	logic [15:0] rd_word_reg;

	always_ff @(posedge clk_link) begin
		if (!lrst_n) begin
			ack_sync_reg <= '0;
			rd_word_reg <= rmi_pkg::WORD_RST;
		end else begin
			ack_sync_reg <= {ack_sync_reg[1:0], ack_tgl_reg};
			if (ack_sync_reg[2] != ack_sync_reg[1]) begin
				rd_word_reg <= fetch_word_reg;
			end
		end
	end

	// ==========================================
	// link domain: target engine
	rmi_pkg::rmi_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] rx_reg;
	logic [7:0] tx_reg;
	logic hi_byte_reg;
	logic master_ack_reg;
	logic [7:0] own_addr;
	logic addr_match;

	assign own_addr = strap_reg ? rmi_pkg::ADDR_BYTE_FLOAT : rmi_pkg::ADDR_BYTE_GND; // RULE5 RULE6 RULE7
	assign addr_match = rx_reg[7:1] == own_addr[7:1]; // RULE5

	always_ff @(posedge clk_link) begin
		if (!lrst_n) begin
			state_reg <= rmi_pkg::ST_IDLE;
			bit_cnt_reg <= rmi_pkg::BIT_CNT_RST;
			rx_reg <= '0;
			tx_reg <= '0;
			hi_byte_reg <= 1'b0;
			master_ack_reg <= 1'b0;
			ptr_reg <= rmi_pkg::PTR_RST;
			req_tgl_reg <= 1'b0;
		end else if (stop_det) begin
			state_reg <= rmi_pkg::ST_IDLE; // RULE3
		end else if (start_det) begin
			state_reg <= rmi_pkg::ST_ADDR; // RULE3
			bit_cnt_reg <= rmi_pkg::BIT_CNT_RST;
		end else begin
			if (scl_rise) begin
				unique case (state_reg)
					rmi_pkg::ST_ADDR, rmi_pkg::ST_PTR, rmi_pkg::ST_WDATA: begin
						rx_reg <= {rx_reg[6:0], sda_reg};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					rmi_pkg::ST_RDATA_ACK: master_ack_reg <= !sda_reg; // RULE3
					default: ;
				endcase
			end
			if (scl_fall) begin
				unique case (state_reg)
					rmi_pkg::ST_ADDR: begin
						if (bit_cnt_reg == rmi_pkg::BITS_PER_BYTE) begin
							if (addr_match) begin
								state_reg <= rmi_pkg::ST_ADDR_ACK; // RULE4
								if (rx_reg[rmi_pkg::ADDR_RW_BIT]) begin
									req_tgl_reg <= ~req_tgl_reg;
								end
							end else begin
								state_reg <= rmi_pkg::ST_IDLE;
							end
						end
					end
					rmi_pkg::ST_ADDR_ACK: begin
						bit_cnt_reg <= rmi_pkg::BIT_CNT_RST;
						if (rx_reg[rmi_pkg::ADDR_RW_BIT]) begin
							state_reg <= rmi_pkg::ST_RDATA;
							tx_reg <= rd_word_reg[7:0]; // RULE4
							hi_byte_reg <= 1'b1;
						end else begin
							state_reg <= rmi_pkg::ST_PTR;
						end
					end
					rmi_pkg::ST_PTR: begin
						if (bit_cnt_reg == rmi_pkg::BITS_PER_BYTE) begin
							state_reg <= rmi_pkg::ST_PTR_ACK; // RULE4
							ptr_reg <= rx_reg;
						end
					end
					rmi_pkg::ST_WDATA: begin
						if (bit_cnt_reg == rmi_pkg::BITS_PER_BYTE) begin
							state_reg <= rmi_pkg::ST_WDATA_ACK; // RULE12 RULE2
						end
					end
					rmi_pkg::ST_PTR_ACK, rmi_pkg::ST_WDATA_ACK: begin
						state_reg <= rmi_pkg::ST_WDATA; // RULE12
						bit_cnt_reg <= rmi_pkg::BIT_CNT_RST;
					end
					rmi_pkg::ST_RDATA: begin
						if (bit_cnt_reg == rmi_pkg::LAST_TX_BIT) begin
							state_reg <= rmi_pkg::ST_RDATA_ACK;
						end else begin
							tx_reg <= {tx_reg[6:0], 1'b0};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
					rmi_pkg::ST_RDATA_ACK: begin
						bit_cnt_reg <= rmi_pkg::BIT_CNT_RST;
						if (master_ack_reg) begin
							state_reg <= rmi_pkg::ST_RDATA;
							tx_reg <= hi_byte_reg ? rd_word_reg[15:8] : rd_word_reg[7:0]; // RULE4
							hi_byte_reg <= ~hi_byte_reg;
						end else begin
							state_reg <= rmi_pkg::ST_IDLE; // RULE3
						end
					end
					default: ;
				endcase
			end
		end
	end

	// target only: data is pulled low, clock is never driven
	assign sda_o = 1'b0; // RULE1
	always_comb begin
		unique case (state_reg)
			rmi_pkg::ST_ADDR_ACK, rmi_pkg::ST_PTR_ACK, rmi_pkg::ST_WDATA_ACK: sda_oe = 1'b1; // RULE4 RULE12
			rmi_pkg::ST_RDATA: sda_oe = !tx_reg[7]; // RULE4
			default: sda_oe = 1'b0;
		endcase
	end

endmodule : rmi_target

/* tb/rmi_target_properties.sv */
// concurrent checks on the monitor target ports
`timescale 1ns/10ps
module rmi_target_chk (
	input wire logic clk_sys, // system clock
	input wire logic nrst, // reset
	input wire logic clk_link, // link clock
	input wire logic scl_i, // clock pin
	input wire logic sda_i, // data pin
	input wire logic sda_o, // data value
	input wire logic sda_oe, // data enable
	input wire logic addr_strap_i, // strap
	input wire logic remote_en_n_i, // enable pin
	input wire logic module_on, // on
	input wire rmi_pkg::rmi_fault_t fault_i, // faults
	input wire rmi_pkg::rmi_tele_t tele_i, // readings
	input wire rmi_pkg::rmi_fault_t fault_log // log
);
	// ==========================================
	// enable and fault log
	property p_on;
		@(posedge clk_sys) disable iff (!nrst) !remote_en_n_i [*6] |-> module_on;
	endproperty
	a_on: assert property (p_on) else $error("module off while enabled");
	property p_off;
		@(posedge clk_sys) disable iff (!nrst) remote_en_n_i [*6] |-> !module_on;
	endproperty
	a_off: assert property (p_off) else $error("module on while released");
	property p_log_set;
		@(posedge clk_sys) disable iff (!nrst) fault_i != 5'h00 |=> (fault_log & $past(fault_i)) == $past(fault_i);
	endproperty
	a_log_set: assert property (p_log_set) else $error("fault not logged");
	property p_log_keep;
		@(posedge clk_sys) disable iff (!nrst)
			module_on ##1 module_on |-> (fault_log & $past(fault_log)) == $past(fault_log);
	endproperty
	a_log_keep: assert property (p_log_keep) else $error("log lost while on");
	property p_log_clr;
		@(posedge clk_sys) disable iff (!nrst) (fault_i == 5'h00) [*2] ##0 $fell(module_on) |=> fault_log == 5'h00;
	endproperty
	a_log_clr: assert property (p_log_clr) else $error("log kept after off");
	// ==========================================
	// data line
	property p_sda_o;
		@(posedge clk_sys) disable iff (!nrst) sda_o == 1'b0;
	endproperty
	a_sda_o: assert property (p_sda_o) else $error("data driven high");
	property p_sda_hold;
		@(posedge clk_link) disable iff (!nrst) scl_i && $past(scl_i) |-> $stable(sda_oe);
	endproperty
	a_sda_hold: assert property (p_sda_hold) else $error("data moved with clock high");
	// a drive starts only in the low phase and lasts into the high phase
	sequence s_drive_hold;
		!scl_i ##0 sda_oe [*8];
	endsequence
	property p_drive;
		@(posedge clk_link) disable iff (!nrst) $rose(sda_oe) |-> s_drive_hold;
	endproperty
	a_drive: assert property (p_drive) else $error("short or misplaced drive");
endmodule : rmi_target_chk
bind rmi_target rmi_target_chk rmi_target_chk_inst (.clk_sys(clk_sys), .nrst(nrst), .clk_link(clk_link),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_i(addr_strap_i),
	.remote_en_n_i(remote_en_n_i), .module_on(module_on), .fault_i(fault_i), .tele_i(tele_i),
	.fault_log(fault_log));

/* tb/rmi_master.sv */
// two-wire bus master model
`timescale 1ns/10ps
module rmi_master (
	input wire logic clk_link, // link clock
	input wire logic sda, // resolved data line
	output logic scl, // clock line
	output logic sda_low // pulls data low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// moves on the falling edge so the target never samples a change
	task automatic w(input int n);
		repeat (n) @(negedge clk_link);
	endtask : w
	// ==========================================
	// framing
	// short bits keep five reads inside the run budget; the target answers 4 cycles after a fall
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		w(2);
		scl = 1'b1;
		w(3);
		r = sda;
		scl = 1'b0;
		w(4);
	endtask : bit_io
	task automatic start;
		sda_low = 1'b0;
		w(2);
		scl = 1'b1;
		w(3);
		sda_low = 1'b1;
		w(3);
		scl = 1'b0;
		w(4);
	endtask : start
	task automatic stop;
		sda_low = 1'b1;
		w(2);
		scl = 1'b1;
		w(3);
		sda_low = 1'b0;
		w(3);
	endtask : stop
	task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(!ack_in, r);
		ack = !r;
	endtask : byte_io
	// ==========================================
	// transactions
	task automatic rd(input logic [7:0] aw, input logic [7:0] ptr, input logic extra, output logic [15:0] wd,
		output logic [3:0] ak);
		logic [7:0] q;
		ak[3] = 1'b1;
		start;
		byte_io(aw, 1'b0, q, ak[0]);
		byte_io(ptr, 1'b0, q, ak[1]);
		if (extra) begin
			byte_io(8'hA5, 1'b0, q, ak[3]);
		end
		start;
		byte_io(aw | 8'h01, 1'b0, q, ak[2]);
		byte_io(8'hFF, 1'b1, wd[7:0], q[0]);
		byte_io(8'hFF, 1'b0, wd[15:8], q[0]);
		stop;
	endtask : rd
	task automatic probe(input logic [7:0] aw, output logic ak);
		logic [7:0] q;
		start;
		byte_io(aw, 1'b0, q, ak);
		stop;
	endtask : probe
endmodule : rmi_master

/* tb/rmi_target_tb.sv */
// self-checking bench for the monitor target
`timescale 1ns/10ps
module rmi_target_tb;
	logic clk_sys = 1'b0;
	logic clk_link = 1'b0;
	logic nrst = 1'b0;
	logic strap = 1'b1;
	logic en_n = 1'b1;
	logic scl, sda_low, sda_oe, module_on;
	wire logic sda;
	rmi_pkg::rmi_fault_t fault = 5'h00;
	rmi_pkg::rmi_fault_t fault_log;
	rmi_pkg::rmi_tele_t tele = 64'h6D60_6D3A_0BB8_002A;
	int n_fail = 0;
	int checked = 0;
	int cycles = 0;
	assign sda = !(sda_low | sda_oe);
	always #2 clk_sys = !clk_sys;
	initial begin
		#13;
		forever #80 clk_link = !clk_link;
	end
	rmi_target rmi_target_inst (.clk_sys(clk_sys), .nrst(nrst), .clk_link(clk_link), .scl_i(scl), .sda_i(sda),
		.sda_o(), .sda_oe(sda_oe), .addr_strap_i(strap), .remote_en_n_i(en_n), .module_on(module_on),
		.fault_i(fault), .tele_i(tele), .fault_log(fault_log));
	rmi_master rmi_master_inst (.clk_link(clk_link), .sda(sda), .scl(scl), .sda_low(sda_low));
	// ==========================================
	// reporting
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 100000) begin
			n_fail++;
			print_verdict;
		end
	end
	// ==========================================
	// scenarios
	task automatic t_enable;
		check({15'h0, module_on}, 16'h0000);
		@(negedge clk_sys) en_n = 1'b0;
		repeat (8) @(negedge clk_sys);
		check({15'h0, module_on}, 16'h0001);
		fault = 5'h08;
		@(negedge clk_sys) fault = 5'h00;
		@(negedge clk_sys);
		check({11'h0, fault_log}, 16'h0008);
		en_n = 1'b1;
		repeat (8) @(negedge clk_sys);
		check({15'h0, module_on}, 16'h0000);
		check({11'h0, fault_log}, 16'h0000);
		en_n = 1'b0;
		fault = 5'h02;
		@(negedge clk_sys) fault = 5'h10;
		repeat (8) @(negedge clk_sys);
		check({11'h0, fault_log}, 16'h0012);
		$display("t_enable done");
	endtask : t_enable
	// status keeps a present fault and the log; the vin read follows a discarded write byte
	task automatic t_reads;
		logic [15:0] wd;
		logic [3:0] ak;
		logic [7:0] ptr[5];
		logic [15:0] exp[5];
		ptr = '{rmi_pkg::PTR_STATUS, rmi_pkg::PTR_VIN, rmi_pkg::PTR_OUTPUT_VOLTAGE_READING, rmi_pkg::PTR_OUTPUT_CURRENT_READING, rmi_pkg::PTR_TEMP};
		exp = '{16'h1210, 16'h6D60, 16'h6D3A, 16'h0BB8, 16'h002A};
		for (int i = 0; i < 5; i++) begin
			@(negedge clk_sys) strap = ((i % 2) == 0);
			repeat (6) @(negedge clk_link);
			rmi_master_inst.rd(strap ? rmi_pkg::ADDR_BYTE_FLOAT : rmi_pkg::ADDR_BYTE_GND, ptr[i], i == 1, wd, ak);
			check({12'h000, ak}, 16'h000F);
			check(wd, exp[i]);
		end
		check({11'h0, fault_log}, 16'h0012);
		$display("t_reads done");
	endtask : t_reads
	task automatic t_wrong;
		logic ak;
		@(negedge clk_sys) strap = 1'b0;
		repeat (6) @(negedge clk_link);
		rmi_master_inst.probe(rmi_pkg::ADDR_BYTE_FLOAT, ak);
		check({15'h0, ak}, 16'h0000);
		$display("t_wrong done");
	endtask : t_wrong
	// reset spans several link cycles so the link side sees it
	initial begin
		repeat (5) @(negedge clk_link);
		@(negedge clk_sys) nrst = 1'b1;
		repeat (10) @(negedge clk_link);
		t_enable;
		t_reads;
		t_wrong;
		print_verdict;
	end
endmodule : rmi_target_tb
